//--- pfw_pkg.sv
// Constants and carrier types for the posted fast register write block
//
// How it works
// - Without fast mode, a request register write retires after more than 1000 cycles.
// - With fast mode, the request register write retires after about 100 cycles.
// - Fast writes are posted; retirement waits for the uncore only while an older write still occupies the buffer.
// - Later writes to one register reach the uncore after earlier ones.
// - Capability, control and status registers exist once per logical processor.
// - Capability bit 0 is read-only and reports fast write support.
// - Control bit 0 is read-write, resets to 0, and turns fast mode on.
// - Setting the enable bit also sets identification leaf 6 EAX bit 18 when the request register is present.
// - The enable bit sets once; later writes are ignored until reset.
// - A capable register without opt-in control is always written fast.
// - One status bit per fast register shows whether data is visible outside.
// - Status bit 0 reads 1 while the last write is in flight, else 0.
// - Bits 63 to 1 of the three registers read zero; writes there are dropped.
// - The request register exists only when leaf 6 EAX bit 7 is set.
// - With leaf 6 EAX bit 18 set, request writes use the fast posted path.
package pfw_pkg;

  localparam int REG_ADDR_W = 12;
  localparam int REG_DATA_W = 64;
  localparam int ID_WORD_W = 32;

  // Register indices seen by the register write instruction
  localparam logic [REG_ADDR_W-1:0] ADDR_CTL = 12'h657;
  localparam logic [REG_ADDR_W-1:0] ADDR_STATUS = 12'h65E;
  localparam logic [REG_ADDR_W-1:0] ADDR_CAPABILITY = 12'h65F;
  localparam logic [REG_ADDR_W-1:0] ADDR_PERF_REQ = 12'h700;

  // Field positions
  localparam int FAST_REQ_BIT = 0;
  localparam int ID_PERF_PRESENT_BIT = 7;
  localparam int ID_FAST_REQ_BIT = 18;

  // Values after reset
  localparam logic CTL_ENABLE_RESET = 1'b0;
  localparam logic [REG_DATA_W-1:0] PERF_REQ_RESET = 64'h0000000000000000;

  // Retirement costs in core cycles
  localparam int SLOW_RETIRE_CYCLES = 1001;
  localparam int FAST_RETIRE_CYCLES = 100;
  localparam int RETIRE_CNT_W = $clog2(SLOW_RETIRE_CYCLES + 1);
  localparam logic [RETIRE_CNT_W-1:0] SLOW_RETIRE_LAST = RETIRE_CNT_W'(SLOW_RETIRE_CYCLES - 1);
  localparam logic [RETIRE_CNT_W-1:0] FAST_RETIRE_LAST = RETIRE_CNT_W'(FAST_RETIRE_CYCLES - 1);

  typedef enum logic [1:0] {
    PFW_ST_IDLE = 2'b00,
    PFW_ST_POST = 2'b01,
    PFW_ST_RETIRE = 2'b11,
    PFW_ST_ANSWER = 2'b10
  } pfw_state_type;

  // One register access from the core
  typedef struct packed {
    logic write;
    logic [7:0] lp;
    logic [REG_ADDR_W-1:0] addr;
    logic [REG_DATA_W-1:0] wdata;
  } pfw_cmd_type;

  // Answer to the core
  typedef struct packed {
    logic valid;
    logic unmapped;
    logic [REG_DATA_W-1:0] rdata;
  } pfw_rsp_type;

endpackage

//--- pfw_post_buf.sv
// Single-entry in-order posting buffer toward the uncore
`timescale 1ns/1ps
`default_nettype none
module pfw_post_buf #(
  parameter int DATA_W = 64
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Core side
  input wire logic push,
  input wire logic [DATA_W-1:0] push_data,
  output logic ready,
  // Uncore side
  output logic out_valid_q,
  output logic [DATA_W-1:0] out_data_q,
  input wire logic out_ack
);

  // Accept only when empty or draining now, so entries never reorder
  assign ready = ~out_valid_q | out_ack;

  // Push wins over a simultaneous acknowledge: the newer entry stays pending
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      out_valid_q <= 1'b0;
    end else if (push && ready) begin
      out_valid_q <= 1'b1;
    end else if (out_ack) begin
      out_valid_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      out_data_q <= '0;
    end else if (push && ready) begin
      out_data_q <= push_data;
    end
  end

endmodule
`default_nettype wire

//--- pfw_top.sv
// Posted fast write path for the per-processor performance request register
`timescale 1ns/1ps
`default_nettype none
module pfw_top #(
  parameter int NUM_LP = 2,
  parameter bit FAST_CAPABLE = 1'b1,
  parameter bit HAS_OPT_IN = 1'b1,
  parameter bit PERF_PRESENT = 1'b1,
  parameter logic [pfw_pkg::ID_WORD_W-1:0] ID_BASE_FLAGS = 32'h00000000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Core register access port
  input wire logic cmd_valid,
  input wire pfw_pkg::pfw_cmd_type cmd,
  output logic cmd_ready_q,
  output pfw_pkg::pfw_rsp_type rsp_q,
  // Identification leaf 6 EAX per logical processor
  output logic [NUM_LP-1:0][pfw_pkg::ID_WORD_W-1:0] id_leaf6_eax_q,
  // Uncore power management side
  output logic [NUM_LP-1:0] up_valid_q,
  output logic [NUM_LP-1:0][pfw_pkg::REG_DATA_W-1:0] up_data_q,
  input wire logic [NUM_LP-1:0] up_ack
);
  import pfw_pkg::*;

  localparam int LP_W = (NUM_LP > 1) ? $clog2(NUM_LP) : 1;

  // Decoded register selection
  typedef enum logic [2:0] {
    PFW_SEL_NONE = 3'd0,
    PFW_SEL_CTL = 3'd1,
    PFW_SEL_STATUS = 3'd2,
    PFW_SEL_CAP = 3'd3,
    PFW_SEL_PERF = 3'd4
  } pfw_sel_type;

  // Address decode, shared by the read and write paths
  function automatic pfw_sel_type decode_addr(input logic [REG_ADDR_W-1:0] addr);
    pfw_sel_type sel;
    sel = PFW_SEL_NONE;
    case (addr)
      ADDR_CTL: begin
        sel = PFW_SEL_CTL;
      end
      ADDR_STATUS: begin
        sel = PFW_SEL_STATUS;
      end
      ADDR_CAPABILITY: begin
        sel = PFW_SEL_CAP;
      end
      ADDR_PERF_REQ: begin
        // Absent unless the feature is reported present
        sel = PERF_PRESENT ? PFW_SEL_PERF : PFW_SEL_NONE;
      end
      default: begin
        sel = PFW_SEL_NONE;
      end
    endcase
    return sel;
  endfunction

  // Places a single flag in bit 0 of a register, rest zero
  function automatic logic [REG_DATA_W-1:0] flag_word(input logic flag);
    logic [REG_DATA_W-1:0] w;
    w = '0;
    w[FAST_REQ_BIT] = flag;
    return w;
  endfunction

  // Latched command
  pfw_state_type state_q;
  pfw_state_type state_d;
  pfw_cmd_type cmd_q;
  pfw_sel_type sel_q;
  logic [LP_W-1:0] lp_q;
  logic lp_ok_q;
  logic [RETIRE_CNT_W-1:0] cnt_q;
  logic fast_q;

  // Per logical processor state
  logic [NUM_LP-1:0] ctl_en_q;
  logic [NUM_LP-1:0] fast_mode;
  logic [NUM_LP-1:0][REG_DATA_W-1:0] perf_req_q;
  logic [NUM_LP-1:0] buf_push;
  logic [NUM_LP-1:0] buf_ready;

  // Command decode helpers
  logic lp_hit;
  logic cur_ready;
  logic cur_inflight;
  logic retire_done;

  // Fast mode per processor: opt-in bit when present, else on whenever capable
  genvar g;
  generate
    for (g = 0; g < NUM_LP; g++) begin : g_lp
      if (HAS_OPT_IN) begin : g_optin
        assign fast_mode[g] = FAST_CAPABLE & ctl_en_q[g];
      end else begin : g_always
        assign fast_mode[g] = FAST_CAPABLE;
      end

      // Enable bit: set once, only reset clears it
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          ctl_en_q[g] <= CTL_ENABLE_RESET;
        end else if (state_q == PFW_ST_POST && cmd_q.write && sel_q == PFW_SEL_CTL
                     && lp_ok_q && lp_q == LP_W'(g) && !ctl_en_q[g]) begin
          // Only bit 0 counts; reserved bits are dropped
          ctl_en_q[g] <= cmd_q.wdata[FAST_REQ_BIT] & FAST_CAPABLE & HAS_OPT_IN;
        end
      end

      // Architectural copy held inside the processor
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          perf_req_q[g] <= PERF_REQ_RESET;
        end else if (buf_push[g]) begin
          perf_req_q[g] <= cmd_q.wdata;
        end
      end

      assign buf_push[g] = state_q == PFW_ST_POST && cmd_q.write && sel_q == PFW_SEL_PERF
                           && lp_ok_q && lp_q == LP_W'(g) && buf_ready[g];

      // One posting buffer per processor, for the request register only
      pfw_post_buf #(
        .DATA_W(REG_DATA_W)
      ) u_post (
        .clk(clk),
        .nrst(nrst),
        .push(buf_push[g]),
        .push_data(cmd_q.wdata),
        .ready(buf_ready[g]),
        .out_valid_q(up_valid_q[g]),
        .out_data_q(up_data_q[g]),
        .out_ack(up_ack[g])
      );

      // Identification word follows fast mode, gated by request register presence
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          id_leaf6_eax_q[g] <= '0;
        end else begin
          id_leaf6_eax_q[g] <= ID_BASE_FLAGS;
          id_leaf6_eax_q[g][ID_PERF_PRESENT_BIT] <= PERF_PRESENT;
          id_leaf6_eax_q[g][ID_FAST_REQ_BIT] <= fast_mode[g] & PERF_PRESENT;
        end
      end
    end
  endgenerate

  assign lp_hit = 32'(cmd.lp) < NUM_LP;
  assign cur_ready = lp_ok_q ? buf_ready[lp_q] : 1'b1;
  assign cur_inflight = lp_ok_q ? up_valid_q[lp_q] : 1'b0;

  // Slow writes wait both for the long cost and for the data to land
  assign retire_done = fast_q ? (cnt_q == FAST_RETIRE_LAST)
                              : (cnt_q == SLOW_RETIRE_LAST && !cur_inflight);

  // Command sequencing
  always_comb begin
    state_d = state_q;
    case (state_q)
      PFW_ST_IDLE: begin
        // Taken only with ready shown, so nothing is taken on the first edge after reset
        if (cmd_valid && cmd_ready_q) begin
          state_d = PFW_ST_POST;
        end
      end
      PFW_ST_POST: begin
        // Hold a request write while an older one still occupies the buffer
        if (cmd_q.write && sel_q == PFW_SEL_PERF) begin
          if (cur_ready) begin
            state_d = PFW_ST_RETIRE;
          end
        end else begin
          state_d = PFW_ST_ANSWER;
        end
      end
      PFW_ST_RETIRE: begin
        if (retire_done) begin
          state_d = PFW_ST_ANSWER;
        end
      end
      PFW_ST_ANSWER: begin
        state_d = PFW_ST_IDLE;
      end
      default: begin
        state_d = PFW_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= PFW_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Capture the command when accepted
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmd_q <= '0;
      sel_q <= PFW_SEL_NONE;
      lp_q <= '0;
      lp_ok_q <= 1'b0;
    end else if (state_q == PFW_ST_IDLE && cmd_valid && cmd_ready_q) begin
      cmd_q <= cmd;
      sel_q <= decode_addr(cmd.addr);
      lp_q <= LP_W'(cmd.lp);
      lp_ok_q <= lp_hit;
    end
  end

  // Ready only when idle; one access is handled at a time
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmd_ready_q <= 1'b0;
    end else begin
      cmd_ready_q <= state_d == PFW_ST_IDLE;
    end
  end

  // Retirement counter; the mode is frozen at the moment of posting
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
      fast_q <= 1'b0;
    end else if (state_q == PFW_ST_POST) begin
      cnt_q <= '0;
      fast_q <= lp_ok_q & fast_mode[lp_q];
    end else if (state_q == PFW_ST_RETIRE && !retire_done) begin
      // Counter parks at its end while a slow write waits for the ack
      if (fast_q ? cnt_q != FAST_RETIRE_LAST : cnt_q != SLOW_RETIRE_LAST) begin
        cnt_q <= cnt_q + RETIRE_CNT_W'(1);
      end
    end
  end
  // Fast writes answer at the count end even with data still pending

  // Read data and answer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rsp_q <= '0;
    end else begin
      rsp_q.valid <= state_q == PFW_ST_ANSWER;
      rsp_q.unmapped <= 1'b0;
      rsp_q.rdata <= '0;
      if (state_q == PFW_ST_ANSWER) begin
        if (!lp_ok_q || sel_q == PFW_SEL_NONE) begin
          rsp_q.unmapped <= 1'b1;
        end else if (!cmd_q.write) begin
          case (sel_q)
            PFW_SEL_CTL: begin
              rsp_q.rdata <= flag_word(ctl_en_q[lp_q]);
            end
            PFW_SEL_STATUS: begin
              // Reports the pending posted data, also after retirement
              rsp_q.rdata <= flag_word(up_valid_q[lp_q]);
            end
            PFW_SEL_CAP: begin
              rsp_q.rdata <= flag_word(FAST_CAPABLE);
            end
            PFW_SEL_PERF: begin
              rsp_q.rdata <= perf_req_q[lp_q];
            end
            default: begin
              rsp_q.rdata <= '0;
            end
          endcase
        end
      end
    end
  end

endmodule
`default_nettype wire

//--- pfw_far_model.sv
// Uncore consumer model for posted request data
`timescale 1ns/1ps
`default_nettype none
module pfw_far_model #(
  parameter int NUM_LP = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Posted data from the block
  input wire logic [NUM_LP-1:0] up_valid_q,
  input wire logic [NUM_LP-1:0][63:0] up_data_q,
  output logic [NUM_LP-1:0] up_ack,
  // Stall control from the bench
  input wire logic [NUM_LP-1:0] hold
);
  logic [63:0] got_q[$];
  // Accept one cycle after data shows; hold models a busy uncore
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      up_ack <= '0;
    end else begin
      for (int i = 0; i < NUM_LP; i++) begin
        up_ack[i] <= up_valid_q[i] && !up_ack[i] && !hold[i];
        if (up_valid_q[i] && up_ack[i]) begin
          got_q.push_back(up_data_q[i]);
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- pfw_asserts.sv
// Port assertions for the posted fast write block
`timescale 1ns/1ps
`default_nettype none
module pfw_asserts #(
  parameter int NUM_LP = 2,
  parameter bit FAST_CAPABLE = 1'b1,
  parameter bit PERF_PRESENT = 1'b1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cmd_valid,
  input wire pfw_pkg::pfw_cmd_type cmd,
  input wire logic cmd_ready_q,
  input wire pfw_pkg::pfw_rsp_type rsp_q,
  input wire logic [NUM_LP-1:0][pfw_pkg::ID_WORD_W-1:0] id_leaf6_eax_q,
  input wire logic [NUM_LP-1:0] up_valid_q,
  input wire logic [NUM_LP-1:0][pfw_pkg::REG_DATA_W-1:0] up_data_q,
  input wire logic [NUM_LP-1:0] up_ack
);
  import pfw_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic take;
  logic req0;
  logic rd_cfg;
  logic [15:0] cnt_q;
  logic fast_q;
  logic slow_q;
  assign take = cmd_valid && cmd_ready_q;
  assign req0 = take && cmd.write && cmd.addr == ADDR_PERF_REQ && cmd.lp == 8'h00;
  assign rd_cfg = take && !cmd.write && cmd.addr inside {ADDR_CTL, ADDR_STATUS, ADDR_CAPABILITY};
  // Cycles since the last accepted access, saturating
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
    end else if (take) begin
      cnt_q <= '0;
    end else if (cnt_q != 16'hFFFF) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fast_q <= 1'b0;
      slow_q <= 1'b0;
    end else if (take) begin
      fast_q <= req0 && id_leaf6_eax_q[0][ID_FAST_REQ_BIT] && !up_valid_q[0];
      slow_q <= req0 && !id_leaf6_eax_q[0][ID_FAST_REQ_BIT];
    end
  end
  fast_retire_a: assert property (rsp_q.valid && fast_q |-> cnt_q >= 16'd100 && cnt_q <= 16'd110)
    else $error("fast write retired outside its window");
  slow_retire_a: assert property (rsp_q.valid && slow_q |-> cnt_q > 16'd1000)
    else $error("slow write retired too early");
  cap_value_a: assert property (take && !cmd.write && cmd.addr == ADDR_CAPABILITY && cmd.lp == 8'h00
    |-> ##3 rsp_q.valid && rsp_q.rdata == 64'(FAST_CAPABLE)) else $error("capability read wrong");
  reserved_zero_a: assert property (rd_cfg |-> ##3 rsp_q.rdata[63:1] == '0)
    else $error("reserved bits read nonzero");
  enable_sticky_a: assert property (id_leaf6_eax_q[0][ID_FAST_REQ_BIT] |=> id_leaf6_eax_q[0][ID_FAST_REQ_BIT])
    else $error("fast mode dropped without reset");
  present_flag_a: assert property (take |-> id_leaf6_eax_q[0][ID_PERF_PRESENT_BIT] == PERF_PRESENT)
    else $error("presence flag wrong");
  ack_drains_a: assert property (up_valid_q[0] && up_ack[0] |=> !up_valid_q[0] || $changed(up_data_q[0]))
    else $error("pending data kept after acknowledge");
  no_overtake_a: assert property (up_valid_q[0] && !up_ack[0] |=> up_valid_q[0] && $stable(up_data_q[0]))
    else $error("pending data replaced before acknowledge");
  cover property (rsp_q.valid && fast_q);
  cover property (rsp_q.valid && slow_q);
  cover property (up_valid_q[0] && up_ack[0]);
endmodule
bind pfw_top pfw_asserts #(.NUM_LP(NUM_LP), .FAST_CAPABLE(FAST_CAPABLE), .PERF_PRESENT(PERF_PRESENT)) u_chk (
  .clk(clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready_q(cmd_ready_q), .rsp_q(rsp_q),
  .id_leaf6_eax_q(id_leaf6_eax_q), .up_valid_q(up_valid_q), .up_data_q(up_data_q), .up_ack(up_ack));
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the posted fast write block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pfw_pkg::*;
  logic clk, nrst, cmd_valid, cmd_ready_q, um;
  pfw_cmd_type cmd;
  pfw_rsp_type rsp_q;
  logic [1:0][ID_WORD_W-1:0] id_q;
  logic [1:0] up_valid_q, up_ack, hold;
  logic [1:0][REG_DATA_W-1:0] up_data_q;
  logic [63:0] rd, d;
  logic [63:0] exp_q[$];
  int fails, checked, seed, n, en;
  pfw_top DUT (.clk(clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready_q(cmd_ready_q),
    .rsp_q(rsp_q), .id_leaf6_eax_q(id_q), .up_valid_q(up_valid_q), .up_data_q(up_data_q), .up_ack(up_ack));
  pfw_far_model u_far (.clk(clk), .nrst(nrst), .up_valid_q(up_valid_q), .up_data_q(up_data_q),
    .up_ack(up_ack), .hold(hold));
  // Variant without opt-in control; only its identification word is checked
  logic [1:0][ID_WORD_W-1:0] id_alt;
  logic [1:0] alt_valid;
  pfw_top #(.HAS_OPT_IN(1'b0)) u_alt (.clk(clk), .nrst(nrst), .cmd_valid(1'b0), .cmd(cmd), .cmd_ready_q(),
    .rsp_q(), .id_leaf6_eax_q(id_alt), .up_valid_q(alt_valid), .up_data_q(), .up_ack(alt_valid));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One access; n counts cycles from acceptance to the answer
  task automatic acc(input logic w, input logic [7:0] lp, input logic [11:0] a, input logic [63:0] wd);
    int k;
    k = 0;
    cmd_valid = 1'b1;
    cmd = '{w, lp, a, wd};
    while (cmd_ready_q !== 1'b1 && k < 5000) begin
      @(posedge clk);
      #1 k++;
    end
    @(posedge clk);
    #1 cmd_valid = 1'b0;
    n = 1;
    while (rsp_q.valid !== 1'b1 && n < 5000) begin
      @(posedge clk);
      #1 n++;
    end
    rd = rsp_q.rdata;
    um = rsp_q.unmapped;
  endtask
  task automatic wr_req(input int lo, input int hi);
    d = {$random(seed), $random(seed)};
    exp_q.push_back(d);
    acc(1'b1, 8'h00, ADDR_PERF_REQ, d);
    chk("retire", 64'(n >= lo && n <= hi), 64'h1);
  endtask
  task automatic end_of_test;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    end_of_test;
  end
  initial begin
    seed = 32'h6cca24e8;
    fails = 0;
    checked = 0;
    nrst = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    hold = 2'b00;
    repeat (8) @(posedge clk);
    #1 nrst = 1'b1;
    for (int i = 0; i < 2; i++) begin
      acc(1'b0, 8'(i), ADDR_CAPABILITY, '0);
      chk("cap", rd, 64'h1);
      acc(1'b0, 8'(i), ADDR_CTL, '0);
      chk("ctl", rd, 64'h0);
      chk("id", 64'(id_q[i]), 64'h80);
      chk("no opt-in", 64'(id_alt[i][18]), 64'h1);
    end
    acc(1'b1, 8'h00, ADDR_CAPABILITY, '0);
    acc(1'b1, 8'h00, ADDR_STATUS, 64'h1);
    acc(1'b0, 8'h00, ADDR_STATUS, '0);
    chk("status", rd, 64'h0);
    acc(1'b0, 8'h02, ADDR_CTL, '0);
    chk("bad lp", {rd[62:0], um}, 64'h1);
    $display("test reset values done");
    wr_req(1001, 1100);
    acc(1'b1, 8'h00, ADDR_CTL, 64'h1);
    // Second write tries to clear the enable
    for (en = 0; en < 2; en++) begin
      acc(1'b0, 8'h00, ADDR_CTL, '0);
      chk("enable", rd, 64'h1);
      chk("flag", {id_q[1][18], id_q[0][18]}, 64'h1);
      acc(1'b1, 8'h00, ADDR_CTL, '0);
    end
    $display("test enable done");
    hold = 2'b01;
    wr_req(100, 110);
    chk("up data", up_data_q[0], d);
    acc(1'b0, 8'h00, ADDR_STATUS, '0);
    chk("inflight", rd, 64'h1);
    fork
      begin
        repeat (200) @(posedge clk);
        #1 hold = 2'b00;
      end
      wr_req(200, 400);
    join
    repeat (3) wr_req(100, 110);
    repeat (4) @(posedge clk);
    #1 acc(1'b0, 8'h00, ADDR_STATUS, '0);
    chk("landed", rd, 64'h0);
    chk("count", 64'(u_far.got_q.size()), 64'(exp_q.size()));
    while (exp_q.size() > 0 && u_far.got_q.size() > 0) begin
      chk("order", u_far.got_q.pop_front(), exp_q.pop_front());
    end
    $display("test posted writes done");
    nrst = 1'b0;
    repeat (2) @(posedge clk);
    #1 nrst = 1'b1;
    acc(1'b0, 8'h00, ADDR_CTL, '0);
    chk("ctl reset", {id_q[0][18], rd[62:0]}, 64'h0);
    $display("test second reset done");
    end_of_test;
  end
endmodule
`default_nettype wire
